// ### hw/tcsic_pkg.sv
// package: register map, field layout and constants of the timer clock select and capture block
package tcsic_pkg;

    // ==========================================================
    // bus shape
    localparam int unsigned ADDR_W = 6;
    typedef logic [15:0] tcsic_cnt_t;
    typedef struct packed {
        logic read;
        logic write;
        logic [ADDR_W-1:0] address;
        logic [31:0] writedata;
    } tcsic_avm_req_s;

    // ==========================================================
    // register byte offsets
    localparam logic [ADDR_W-1:0] OFF_CTRL = 6'h00;
    localparam logic [ADDR_W-1:0] OFF_SMCR = 6'h04;
    localparam logic [ADDR_W-1:0] OFF_DIER = 6'h08;
    localparam logic [ADDR_W-1:0] OFF_SR = 6'h0C;
    localparam logic [ADDR_W-1:0] OFF_EGR = 6'h10;
    localparam logic [ADDR_W-1:0] OFF_CCMR = 6'h14;
    localparam logic [ADDR_W-1:0] OFF_CCER = 6'h18;
    localparam logic [ADDR_W-1:0] OFF_CNT = 6'h1C;
    localparam logic [ADDR_W-1:0] OFF_CCR1 = 6'h20;
    localparam logic [ADDR_W-1:0] OFF_CCR2 = 6'h24;
    localparam logic [ADDR_W-1:0] OFF_PSC = 6'h28;

    // ==========================================================
    // field positions
    localparam int CTRL_RUN = 0;
    localparam int CTRL_DIR = 1;
    localparam int SMCR_MODE = 0;
    localparam int SMCR_TSRC = 4;
    localparam int SMCR_XFILT = 8;
    localparam int SMCR_XDIV = 12;
    localparam int SMCR_XCLK2 = 14;
    localparam int SMCR_XPOL = 15;
    localparam int DIER_CCIE = 1;
    localparam int DIER_TIE = 6;
    localparam int DIER_CCDE = 9;
    localparam int SR_CCIF = 1;
    localparam int SR_TRIG = 6;
    localparam int SR_CCOF = 9;
    localparam int EGR_FUPD = 0;
    localparam int EGR_CCG = 1;
    localparam int EGR_TG = 6;
    localparam int CCMR_DIR = 0;
    localparam int CCMR_DIV = 2;
    localparam int CCMR_FILT = 4;
    localparam int CCMR_STRIDE = 8;
    localparam int CCER_EN = 0;
    localparam int CCER_POL = 1;
    localparam int CCER_STRIDE = 4;

    // ==========================================================
    // encodings and reset values
    localparam logic [2:0] MODE_OFF = 3'h0;
    localparam logic [2:0] MODE_RESET = 3'h4;
    localparam logic [2:0] MODE_EXT1 = 3'h7;
    localparam logic [2:0] TSRC_IN1_ANY = 3'h4;
    localparam logic [2:0] TSRC_IN1_EDGE = 3'h5;
    localparam logic [2:0] TSRC_IN2_EDGE = 3'h6;
    localparam logic [2:0] TSRC_XTRIG = 3'h7;
    localparam logic [1:0] CHDIR_OUT = 2'h0;
    localparam logic [1:0] CHDIR_OWN = 2'h1;
    localparam logic [1:0] CHDIR_OTHER = 2'h2;
    localparam logic [15:0] RST_REG16 = 16'h0000;
    localparam logic [7:0] RST_REG8 = 8'h00;
    localparam int RUN_LAG = 1;
    // samples needed to accept a new level, per filter code
    localparam logic [4:0] FILT_LEN [16] = '{5'h01, 5'h02, 5'h04, 5'h08, 5'h0A, 5'h0C,
        5'h0E, 5'h10, 5'h12, 5'h14, 5'h16, 5'h18, 5'h1A, 5'h1C, 5'h1E, 5'h1F};

endpackage

// ### hw/tcsic_timer_front.sv
// module: counter clock selection, input filters, slave trigger and two capture channels
module tcsic_timer_front (
    input wire logic clk_sys,
    input wire logic rst,
    input tcsic_pkg::tcsic_avm_req_s avm_req,
    output logic [31:0] avm_readdata,
    output logic avm_waitrequest,
    input wire logic [1:0] chan_in,
    input wire logic external_trigger_pin,
    input wire logic [3:0] timer_chain_trigger,
    output tcsic_pkg::tcsic_cnt_t counter_value,
    output logic counter_run_signal,
    output logic capture_irq_req,
    output logic [1:0] capture_dma_req
);
    import tcsic_pkg::*;

    // ==========================================================
    // registers and shared nets
    logic wait_q;
    logic [31:0] rdata_q;
    logic run_q, dir_q, run_lag_q;
    logic [15:0] smcr_q, ccmr_q, psc_q, pcnt_q;
    logic [7:0] ccer_q;
    logic [10:0] dier_q;
    tcsic_cnt_t cnt_q;
    logic trig_flag_q, irq_q;
    logic [1:0] dma_q;
    logic [2:0] xtrig_div_q;
    logic cap_flag_q [2];
    logic ovr_flag_q [2];
    tcsic_cnt_t preload_q [2];
    tcsic_cnt_t shadow_q [2];
    wire [2:0] rise, fall;
    wire [1:0] cap_evt, soft_evt, ch_edge_raw;
    logic wr, rd, trig_edge, xtrig_edge, xtrig_tick, tick, fupd;
    logic [2:0] slv_mode, trig_sel, xtrig_mask;

    assign wr = avm_req.write & ~wait_q;
    assign rd = avm_req.read & ~wait_q;
    assign slv_mode = smcr_q[SMCR_MODE +: 3];
    assign trig_sel = smcr_q[SMCR_TSRC +: 3];
    assign fupd = wr && avm_req.address == OFF_EGR && avm_req.writedata[EGR_FUPD];

    // ==========================================================
    // avalon slave: one wait cycle, then the access completes
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            wait_q <= 1'b1;
        end else begin
            wait_q <= ~((avm_req.read | avm_req.write) & wait_q);
        end
    end

    // read data is prepared during the wait cycle so it stands when waitrequest drops
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            rdata_q <= 32'h0000_0000;
        end else if (avm_req.read && wait_q) begin
            case (avm_req.address)
                OFF_CTRL: rdata_q <= {30'h0, dir_q, run_q};
                OFF_SMCR: rdata_q <= {16'h0, smcr_q};
                OFF_DIER: rdata_q <= {21'h0, dier_q};
                OFF_SR: rdata_q <= {21'h0, ovr_flag_q[1], ovr_flag_q[0], 2'h0, trig_flag_q,
                    3'h0, cap_flag_q[1], cap_flag_q[0], 1'b0};
                OFF_CCMR: rdata_q <= {16'h0, ccmr_q};
                OFF_CCER: rdata_q <= {24'h0, ccer_q};
                OFF_CNT: rdata_q <= {16'h0, cnt_q};
                OFF_CCR1: rdata_q <= {16'h0, preload_q[0]};
                OFF_CCR2: rdata_q <= {16'h0, preload_q[1]};
                OFF_PSC: rdata_q <= {16'h0, psc_q};
                default: rdata_q <= 32'h0000_0000; // egr and unmapped read zero
            endcase
        end
    end

    // ==========================================================
    // control registers written by software
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            run_q <= 1'b0;
            dir_q <= 1'b0;
            smcr_q <= RST_REG16;
            ccmr_q <= RST_REG16;
            ccer_q <= RST_REG8;
            dier_q <= 11'h000;
            psc_q <= RST_REG16;
        end else if (wr) begin
            case (avm_req.address)
                OFF_CTRL: begin
                    run_q <= avm_req.writedata[CTRL_RUN];
                    dir_q <= avm_req.writedata[CTRL_DIR];
                end
                OFF_SMCR: smcr_q <= avm_req.writedata[15:0];
                OFF_DIER: dier_q <= avm_req.writedata[10:0];
                OFF_CCMR: ccmr_q <= avm_req.writedata[15:0];
                OFF_CCER: ccer_q <= avm_req.writedata[7:0];
                OFF_PSC: psc_q <= avm_req.writedata[15:0];
                default: ;
            endcase
        end
    end

    // run signal lags the run bit by one clock, as the counter logic expects
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            run_lag_q <= 1'b0;
        end else begin
            run_lag_q <= run_q;
        end
    end

    // ==========================================================
    // input conditioning: inputs 0,1 are channel pins, 2 is the external trigger pin
    for (genvar i = 0; i < 3; i++) begin : g_in
        logic s1_q, s2_q, lvl_q, prev_q;
        logic [4:0] fcnt_q;
        logic raw;
        logic [3:0] fsel;
        if (i < 2) begin : g_ch
            assign raw = chan_in[i];
            assign fsel = ccmr_q[i*CCMR_STRIDE+CCMR_FILT +: 4];
        end else begin : g_xtrig
            assign raw = external_trigger_pin;
            assign fsel = smcr_q[SMCR_XFILT +: 4];
        end
        // two flops before anything looks at the pin; s1 feeds only s2
        always_ff @(posedge clk_sys) begin
            if (rst) begin
                s1_q <= 1'b0;
                s2_q <= 1'b0;
            end else begin
                s1_q <= raw;
                s2_q <= s1_q;
            end
        end
        // new level accepted after FILT_LEN equal samples; glitches restart the count
        always_ff @(posedge clk_sys) begin
            if (rst) begin
                lvl_q <= 1'b0;
                prev_q <= 1'b0;
                fcnt_q <= 5'h00;
            end else begin
                prev_q <= lvl_q;
                if (s2_q == lvl_q) begin
                    fcnt_q <= 5'h00;
                end else if (fcnt_q + 5'h01 >= FILT_LEN[fsel]) begin
                    lvl_q <= s2_q;
                    fcnt_q <= 5'h00;
                end else begin
                    fcnt_q <= fcnt_q + 5'h01;
                end
            end
        end
        assign rise[i] = lvl_q & ~prev_q; // single-cycle pulse
        assign fall[i] = ~lvl_q & prev_q;
    end

    // ==========================================================
    // slave trigger selection; input1/input2 edges, the external trigger edge or chain triggers 0..3 reach it
    always_comb begin
        case (trig_sel)
            TSRC_IN1_ANY: trig_edge = rise[0] | fall[0];
            TSRC_IN1_EDGE: trig_edge = ch_edge_raw[0];
            TSRC_IN2_EDGE: trig_edge = ch_edge_raw[1];
            TSRC_XTRIG: trig_edge = xtrig_edge;
            default: trig_edge = timer_chain_trigger[trig_sel[1:0]];
        endcase
    end
    assign ch_edge_raw[0] = ccer_q[CCER_POL] ? fall[0] : rise[0];
    assign ch_edge_raw[1] = ccer_q[CCER_STRIDE+CCER_POL] ? fall[1] : rise[1];

    // external trigger edge and its divider; polarity 0 is the rising edge
    assign xtrig_edge = smcr_q[SMCR_XPOL] ? fall[2] : rise[2];
    assign xtrig_mask = 3'((4'h1 << smcr_q[SMCR_XDIV +: 2]) - 4'h1);
    assign xtrig_tick = xtrig_edge && ((xtrig_div_q & xtrig_mask) == xtrig_mask);
    always_ff @(posedge clk_sys) begin
        if (rst || !smcr_q[SMCR_XCLK2]) begin
            xtrig_div_q <= 3'h0;
        end else if (xtrig_edge) begin
            xtrig_div_q <= xtrig_div_q + 3'h1;
        end
    end

    // ==========================================================
    // counter clock: ext mode 2 overrides slave mode, then ext mode 1, else core clock
    always_comb begin
        if (smcr_q[SMCR_XCLK2]) begin
            tick = xtrig_tick;
        end else if (slv_mode == MODE_EXT1) begin
            tick = trig_edge;
        end else begin
            tick = 1'b1;
        end
    end

    // prescaler and counter; reset mode and force update restart both
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            cnt_q <= RST_REG16;
            pcnt_q <= RST_REG16;
        end else if (fupd || (slv_mode == MODE_RESET && trig_edge)) begin
            cnt_q <= RST_REG16;
            pcnt_q <= RST_REG16;
        end else if (run_lag_q && tick) begin
            if (pcnt_q == psc_q) begin
                pcnt_q <= RST_REG16;
                cnt_q <= dir_q ? cnt_q - 16'h0001 : cnt_q + 16'h0001;
            end else begin
                pcnt_q <= pcnt_q + 16'h0001;
            end
        end
    end

    // trigger flag: set wins over a software clear in the same cycle
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            trig_flag_q <= 1'b0;
        end else if ((trig_edge && slv_mode != MODE_OFF) ||
                (wr && avm_req.address == OFF_EGR && avm_req.writedata[EGR_TG])) begin
            trig_flag_q <= 1'b1;
        end else if (wr && avm_req.address == OFF_SR && !avm_req.writedata[SR_TRIG]) begin
            trig_flag_q <= 1'b0;
        end
    end

    // ==========================================================
    // capture channels
    for (genvar c = 0; c < 2; c++) begin : g_cap
        logic [1:0] dsel, dsel_div;
        logic en, raw_cap, copy_q, wr_ccr, rd_ccr;
        logic [2:0] dcnt_q, dmask;
        logic sel_edge;
        assign dsel = ccmr_q[c*CCMR_STRIDE+CCMR_DIR +: 2];
        assign dsel_div = ccmr_q[c*CCMR_STRIDE+CCMR_DIV +: 2];
        assign en = ccer_q[c*CCER_STRIDE+CCER_EN];
        assign wr_ccr = wr && avm_req.address == (c == 0 ? OFF_CCR1 : OFF_CCR2);
        assign rd_ccr = rd && avm_req.address == (c == 0 ? OFF_CCR1 : OFF_CCR2);
        // own pin with own polarity, or the other pin with this channel's polarity
        always_comb begin
            case (dsel)
                CHDIR_OWN: sel_edge = ch_edge_raw[c];
                CHDIR_OTHER: begin
                    sel_edge = ccer_q[c*CCER_STRIDE+CCER_POL] ? fall[1-c] : rise[1-c];
                end
                default: sel_edge = (dsel != CHDIR_OUT) && trig_edge;
            endcase
        end
        assign raw_cap = sel_edge && en && dsel != CHDIR_OUT;
        assign dmask = 3'((4'h1 << dsel_div) - 4'h1);
        assign cap_evt[c] = raw_cap && ((dcnt_q & dmask) == dmask);
        assign soft_evt[c] = wr && avm_req.address == OFF_EGR &&
            avm_req.writedata[EGR_CCG+c];
        // event divider applies only to captures, never to the slave trigger
        always_ff @(posedge clk_sys) begin
            if (rst || !en) begin
                dcnt_q <= 3'h0;
            end else if (raw_cap) begin
                dcnt_q <= dcnt_q + 3'h1;
            end
        end
        // capture lands in shadow, then copies to preload; compare mode copies back
        always_ff @(posedge clk_sys) begin
            if (rst) begin
                shadow_q[c] <= RST_REG16;
                preload_q[c] <= RST_REG16;
                copy_q <= 1'b0;
            end else begin
                copy_q <= cap_evt[c];
                if (cap_evt[c]) begin
                    shadow_q[c] <= cnt_q;
                end else if (dsel == CHDIR_OUT) begin
                    shadow_q[c] <= preload_q[c];
                end
                if (copy_q) begin
                    preload_q[c] <= shadow_q[c];
                end else if (wr_ccr && dsel == CHDIR_OUT) begin // read-only in input
                    preload_q[c] <= avm_req.writedata[15:0];
                end
            end
        end
        // flags: a hardware set beats a software clear arriving in the same cycle
        always_ff @(posedge clk_sys) begin
            if (rst) begin
                cap_flag_q[c] <= 1'b0;
                ovr_flag_q[c] <= 1'b0;
            end else begin
                if (cap_evt[c] || soft_evt[c]) begin
                    cap_flag_q[c] <= 1'b1;
                end else if (rd_ccr || (wr && avm_req.address == OFF_SR &&
                        !avm_req.writedata[SR_CCIF+c])) begin
                    cap_flag_q[c] <= 1'b0;
                end
                if (cap_evt[c] && cap_flag_q[c]) begin
                    ovr_flag_q[c] <= 1'b1;
                end else if (wr && avm_req.address == OFF_SR &&
                        !avm_req.writedata[SR_CCOF+c]) begin
                    ovr_flag_q[c] <= 1'b0;
                end
            end
        end
    end

    // ==========================================================
    // request outputs: irq is a level from flags, dma a one-cycle pulse per event
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            irq_q <= 1'b0;
            dma_q <= 2'h0;
        end else begin
            irq_q <= (cap_flag_q[0] & dier_q[DIER_CCIE]) | (cap_flag_q[1] &
                dier_q[DIER_CCIE+1]) | (trig_flag_q & dier_q[DIER_TIE]);
            dma_q <= (cap_evt | soft_evt) & dier_q[DIER_CCDE +: 2];
        end
    end

    assign avm_readdata = rdata_q;
    assign avm_waitrequest = wait_q;
    assign counter_value = cnt_q;
    assign counter_run_signal = run_lag_q;
    assign capture_irq_req = irq_q;
    assign capture_dma_req = dma_q;

    // ==========================================================
    // checks
    run_delay_a: assert property (@(posedge clk_sys) disable iff (rst)
        $rose(run_q) |=> counter_run_signal && !$past(counter_run_signal))
        else $error("run signal did not follow run bit by one cycle");
    ug_restart_a: assert property (@(posedge clk_sys) disable iff (rst)
        fupd |=> cnt_q == RST_REG16 && pcnt_q == RST_REG16)
        else $error("force update did not restart counter");
    cap_latch_a: assert property (@(posedge clk_sys) disable iff (rst)
        cap_evt[0] |=> shadow_q[0] == $past(cnt_q) ##1 preload_q[0] == $past(cnt_q, 2))
        else $error("capture value not latched into shadow then preload");
    cap_flag_a: assert property (@(posedge clk_sys) disable iff (rst)
        cap_evt[1] |=> cap_flag_q[1])
        else $error("capture flag not set");
    ovr_set_a: assert property (@(posedge clk_sys) disable iff (rst)
        cap_flag_q[0] && cap_evt[0] |=> ovr_flag_q[0])
        else $error("overcapture flag not set");
    cap_gate_a: assert property (@(posedge clk_sys) disable iff (rst)
        !ccer_q[CCER_EN] && ch_edge_raw[0] |=> $stable(shadow_q[0]) || ccmr_q[1:0] == 2'h0)
        else $error("capture taken while disabled");
    ovr_keep_a: assert property (@(posedge clk_sys) disable iff (rst)
        ovr_flag_q[1] && !(wr && avm_req.address == OFF_SR) |=> ovr_flag_q[1])
        else $error("overcapture flag cleared without a write");
    ccr_ro_a: assert property (@(posedge clk_sys) disable iff (rst)
        wr && avm_req.address == OFF_CCR1 && ccmr_q[1:0] != 2'h0 && !g_cap[0].copy_q
        |=> $stable(preload_q[0]))
        else $error("capture register written while channel is input");
    reset_mode_a: assert property (@(posedge clk_sys) disable iff (rst)
        slv_mode == MODE_RESET && trig_edge |=> cnt_q == 16'h0000)
        else $error("reset mode did not clear counter");
    ext1_step_a: assert property (@(posedge clk_sys) disable iff (rst)
        slv_mode == MODE_EXT1 && !smcr_q[SMCR_XCLK2] && trig_edge && run_lag_q &&
        psc_q == 16'h0000 |=> cnt_q != $past(cnt_q) && trig_flag_q)
        else $error("external clock mode 1 edge did not count");

endmodule

// ### verification/tcsic_pulse_src.sv
// pulse source standing in for the pwm and trigger drivers at the pins
module tcsic_pulse_src #(
    parameter int PERIOD = 40
) (
    input wire logic clk_sys,
    input wire logic on,
    input wire logic [7:0] high,
    output logic wave
);
    timeunit 1ns;
    timeprecision 1ns;
    int ph = 0;
    // =============================================
    // phase counter; the level stays low while off so no stray edge leaks out
    initial wave = 1'b0;
    always @(posedge clk_sys) begin
        ph <= (!on || ph == PERIOD - 1) ? 0 : ph + 1;
        wave <= on && (ph < int'(high));
    end
endmodule

// ### verification/timer_clock_select_input_capture_tb_top.sv
// testbench: register tasks and pin scenarios for the clock select and capture block
module timer_clock_select_input_capture_tb_top;
    timeunit 1ns;
    timeprecision 1ns;
    import tcsic_pkg::*;
    logic clk_sys = 1'b0;
    logic rst = 1'b1;
    tcsic_avm_req_s avm_req = '0;
    logic [31:0] rdata;
    logic wreq;
    logic [15:0] cnt;
    logic run;
    logic irq;
    logic [1:0] dma;
    logic [3:0] chain = 4'h0;
    logic [2:0] src_on = 3'b000;
    logic [7:0] hi = 8'h0C;
    logic [2:0] wave;
    logic [31:0] q;
    logic [31:0] a;
    logic [31:0] c0;
    int n_fail = 0;
    int n_tests = 0;
    int cyc = 0;
    // =============================================
    // clock and hang guard; a hang counts as a mismatch
    initial forever #10 clk_sys = ~clk_sys;
    always @(posedge clk_sys) begin
        cyc <= cyc + 1;
        if (cyc == 5000) begin
            n_fail++;
            finish_test();
        end
    end
    tcsic_timer_front i_tcsic_timer_front (.clk_sys(clk_sys), .rst(rst), .avm_req(avm_req),
        .avm_readdata(rdata), .avm_waitrequest(wreq), .chan_in(wave[1:0]),
        .external_trigger_pin(wave[2]), .timer_chain_trigger(chain), .counter_value(cnt),
        .counter_run_signal(run), .capture_irq_req(irq), .capture_dma_req(dma));
    tcsic_pulse_src u_src[2:0] (.clk_sys(clk_sys), .on(src_on), .high(hi), .wave(wave));
    // =============================================
    // bus cycle: request held until the edge that sees waitrequest low
    task automatic bus(input logic w, input logic [5:0] ad, input logic [31:0] d);
        avm_req <= '{read: !w, write: w, address: ad, writedata: d};
        @(posedge clk_sys);
        while (wreq !== 1'b0) @(posedge clk_sys);
        q = rdata;
        avm_req <= '0;
        @(posedge clk_sys);
    endtask
    task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp) begin
            n_fail++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic rdc(input logic [5:0] ad, input logic [31:0] exp);
        bus(1'b0, ad, 32'h0000_0000);
        cmp(q, exp);
    endtask
    // run selected sources for n cycles, then let the resync pipeline drain
    task automatic pulses(input logic [2:0] m, input int n);
        src_on <= m;
        repeat (n) @(posedge clk_sys);
        src_on <= 3'b000;
        repeat (12) @(posedge clk_sys);
    endtask
    task automatic finish_test();
        if (n_fail == 0 && n_tests > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask
    // =============================================
    // main sequence
    initial begin
        repeat (10) @(posedge clk_sys);
        rst <= 1'b0;
        @(posedge clk_sys);
        rdc(OFF_SMCR, 32'h0000_0000);
        rdc(OFF_SR, 32'h0000_0000);
        rdc(6'h3C, 32'h0000_0000); // unmapped place reads zero
        bus(1'b1, OFF_CTRL, 32'h0000_0001);
        cmp({31'h0, run}, 32'h0000_0000);
        @(posedge clk_sys);
        cmp({31'h0, run}, 32'h0000_0001);
        c0 = {16'h0000, cnt};
        repeat (10) @(posedge clk_sys);
        cmp({16'h0000, cnt} - c0, 32'h0000_000A);
        // external clock mode 1 from input 2, rising edges, no filter
        bus(1'b1, OFF_CCMR, 32'h0000_0100);
        bus(1'b1, OFF_SMCR, 32'h0000_0067);
        bus(1'b1, OFF_EGR, 32'h0000_0001);
        rdc(OFF_EGR, 32'h0000_0000);
        pulses(3'b010, 110);
        cmp({16'h0000, cnt}, 32'h0000_0003);
        rdc(OFF_SR, 32'h0000_0040);
        // external clock mode 2, every second rising edge of the trigger pin
        bus(1'b1, OFF_SMCR, 32'h0000_5000);
        bus(1'b1, OFF_EGR, 32'h0000_0001);
        pulses(3'b100, 150);
        cmp({16'h0000, cnt}, 32'h0000_0002);
        // external clock mode 1 from chain trigger 0: each one-cycle pulse counts once
        bus(1'b1, OFF_SMCR, 32'h0000_0007);
        bus(1'b1, OFF_EGR, 32'h0000_0001);
        repeat (3) begin
            chain <= 4'h1;
            @(posedge clk_sys);
            chain <= 4'h0;
            @(posedge clk_sys);
        end
        cmp({16'h0000, cnt}, 32'h0000_0003);
        // pwm input: reset mode on input 1 rising, ch2 falling on input 1
        bus(1'b1, OFF_SMCR, 32'h0000_0054);
        bus(1'b1, OFF_CCMR, 32'h0000_0201);
        bus(1'b1, OFF_CCER, 32'h0000_0031);
        bus(1'b1, OFF_DIER, 32'h0000_0202);
        bus(1'b1, OFF_SR, 32'h0000_0000);
        pulses(3'b001, 200);
        cmp({31'h0, irq}, 32'h0000_0001);
        rdc(OFF_SR, 32'h0000_0646);
        bus(1'b0, OFF_CCR1, 32'h0000_0000);
        a = q;
        rdc(OFF_SR, 32'h0000_0644);
        bus(1'b0, OFF_CCR2, 32'h0000_0000);
        cmp(a - q, 32'h0000_001C);
        bus(1'b1, OFF_SR, 32'h0000_0000);
        rdc(OFF_SR, 32'h0000_0000);
        cmp({31'h0, irq}, 32'h0000_0000);
        bus(1'b1, OFF_CCR1, 32'h0000_1234);
        rdc(OFF_CCR1, a);
        bus(1'b1, OFF_EGR, 32'h0000_0002);
        cmp({30'h0, dma}, 32'h0000_0001);
        rdc(OFF_SR, 32'h0000_0002);
        // capture disabled: the register keeps its old value
        bus(1'b1, OFF_CCER, 32'h0000_0030);
        pulses(3'b001, 100);
        rdc(OFF_CCR1, a);
        // eight-sample filter rejects five-cycle pulses and takes twelve-cycle ones
        bus(1'b1, OFF_CCMR, 32'h0000_0231);
        bus(1'b1, OFF_CCER, 32'h0000_0031);
        bus(1'b1, OFF_SR, 32'h0000_0000);
        hi <= 8'h05;
        pulses(3'b001, 100);
        bus(1'b0, OFF_SR, 32'h0000_0000);
        cmp(q & 32'h0000_0202, 32'h0000_0000);
        hi <= 8'h0C;
        pulses(3'b001, 100);
        bus(1'b0, OFF_SR, 32'h0000_0000);
        cmp(q & 32'h0000_0002, 32'h0000_0002);
        finish_test();
    end
endmodule
